// ---- low_power_mode_sequencer.sv ----
// Local design decisions: the APB register port and the register addresses.
`default_nettype none
// Overview of operation
// [R01] voltage drop in stop forces reset
// [R02] supply back: release reset, warm-up, fast run
// [R03] supply rise within one machine cycle ignored
// [R04] restart oscillators, freeze during whole warm-up
// [R05] warm-up length from software warm-up setting
// [R06] resume next instruction, clear timing prescaler
// [R07] start only oscillators selected before stop
// [R08] low-frequency oscillator restarts from dual or slow
// [R09] cpu halt stops cpu and watchdog only
// [R10] halt states preserve memory, registers, latches
// [R11] program counter held at entry plus two
// [R12] software disables master enable, enables wake source
// [R13] pending release condition blocks halt entry
// [R14] watchdog interrupt before entry blocks halt
// [R15] halt exit clears request, returns prior state
// [R16] any reset ends halt, then warm-up
// [R17] master off: wake resumes without servicing
// [R18] master on: wake services interrupt first
// [R19] timebase-only gates all peripheral clocks but timebase
// [R20] software disables peripherals before timing halt
// [R21] timing-halt exit clears bit, sets timebase latch
// [R22] timebase falling edge wakes, resumes next instruction
// [R23] all enables on: wake services timebase interrupt
// [R24] halt variant follows run speed at request
module low_power_mode_sequencer
    import lpm_seq_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic supply_ok,
    input wire logic master_irq_enable,
    input wire logic [7:0] irq_latch,
    input wire logic [7:0] source_irq_enable,
    input wire logic watchdog_irq,
    input wire logic [7:0] timebase_src_clk,
    output logic vd_reset_out,
    output logic cpu_stop,
    output logic watchdog_stop,
    output logic state_freeze,
    output logic periph_clk_enable,
    output logic timebase_clk_enable,
    output logic int_hf_osc_enable,
    output logic ext_hf_osc_enable,
    output logic ext_lf_osc_enable,
    output logic run_slow,
    output logic tg_clear,
    output logic resume_next,
    output logic irq_service_request,
    output logic timebase_latch_set
);
    // synchronisers: a change counts once stages two and three agree
    logic sup_s1_r, sup_s2_r, sup_s3_r, sup_f_r, sup_prev_r;
    logic sup_f_nxt;
    logic [7:0] tb_s1_r, tb_s2_r, tb_s3_r, tb_f_r, tb_prev_r;
    logic [7:0] tb_f_nxt;

    always_comb begin
        sup_f_nxt = (sup_s2_r == sup_s3_r) ? sup_s3_r : sup_f_r;
        tb_f_nxt = (tb_f_r & (tb_s2_r ^ tb_s3_r)) | (tb_s3_r & ~(tb_s2_r ^ tb_s3_r));
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sup_s1_r <= 1'b1;
            sup_s2_r <= 1'b1;
            sup_s3_r <= 1'b1;
            sup_f_r <= 1'b1;
            sup_prev_r <= 1'b1;
            tb_s1_r <= 8'h00;
            tb_s2_r <= 8'h00;
            tb_s3_r <= 8'h00;
            tb_f_r <= 8'h00;
            tb_prev_r <= 8'h00;
        end else begin
            sup_s1_r <= supply_ok;
            sup_s2_r <= sup_s1_r;
            sup_s3_r <= sup_s2_r;
            sup_f_r <= sup_f_nxt;
            sup_prev_r <= sup_f_r;
            tb_s1_r <= timebase_src_clk;
            tb_s2_r <= tb_s1_r;
            tb_s3_r <= tb_s2_r;
            tb_f_r <= tb_f_nxt;
            tb_prev_r <= tb_f_r;
        end
    end

    // apb decode
    logic acc_wr, acc_rd_setup, wr_ctl, wr_wu, wr_tb, addr_ok;
    assign addr_ok = (paddr == OFF_CONTROL) || (paddr == OFF_WARMUP) ||
                     (paddr == OFF_TIMEBASE) || (paddr == OFF_STATUS);
    assign acc_wr = psel && penable && pwrite;
    assign acc_rd_setup = psel && !penable && !pwrite;
    assign wr_ctl = acc_wr && (paddr == OFF_CONTROL);
    assign wr_wu = acc_wr && (paddr == OFF_WARMUP);
    assign wr_tb = acc_wr && (paddr == OFF_TIMEBASE);
    // read data is captured in setup so the access phase needs no wait state
    assign pready = 1'b1;
    assign pslverr = psel && penable && !addr_ok;

    lpm_state_t state_r, state_nxt;
    logic slow_r, dual_r, hf_ext_r, vd_en_r, tb_en_r;
    logic slow_nxt, dual_nxt, hf_ext_nxt, vd_en_nxt, tb_en_nxt;
    logic [7:0] warmup_r, warmup_nxt;
    logic [2:0] tb_sel_r, tb_sel_nxt;
    logic [31:0] prdata_r, prdata_nxt;
    logic [11:0] cnt_r, cnt_nxt;
    logic [2:0] saved_osc_r, saved_osc_nxt;
    logic ret_slow_r, ret_slow_nxt, from_reset_r, from_reset_nxt;
    logic tg_clear_r, tg_clear_nxt, resume_r, resume_nxt, svc_r, svc_nxt;
    logic tbl_r, tbl_nxt;
    logic in_run, in_stop_seq, in_cpu_halt, in_tb_only;
    logic wake_irq, tb_fall, supply_rise;

    assign in_run = (state_r == ST_RUN_FAST) || (state_r == ST_RUN_SLOW);
    assign in_cpu_halt = (state_r == ST_CPU_HALT_FAST) || (state_r == ST_CPU_HALT_SLOW);
    assign in_tb_only = (state_r == ST_TB_ONLY_FAST) || (state_r == ST_TB_ONLY_SLOW);
    assign in_stop_seq = (state_r == ST_STOP) || (state_r == ST_OSC_START) ||
                         ((state_r == ST_WARMUP) && !from_reset_r);
    assign wake_irq = |(irq_latch & source_irq_enable);
    assign tb_fall = tb_prev_r[tb_sel_r] && !tb_f_r[tb_sel_r];
    assign supply_rise = sup_f_r && !sup_prev_r;

    // register file; a voltage-detect reset returns it to reset values
    always_comb begin
        slow_nxt = slow_r;
        dual_nxt = dual_r;
        hf_ext_nxt = hf_ext_r;
        vd_en_nxt = vd_en_r;
        warmup_nxt = warmup_r;
        tb_en_nxt = tb_en_r;
        tb_sel_nxt = tb_sel_r;
        prdata_nxt = prdata_r;
        if (state_r == ST_VD_RESET) begin
            slow_nxt = 1'b0;
            dual_nxt = 1'b0;
            hf_ext_nxt = 1'b0;
            vd_en_nxt = 1'b0;
            warmup_nxt = WARMUP_RST;
            tb_en_nxt = TB_ENABLE_RST;
            tb_sel_nxt = TB_SEL_RST;
        end else begin
            if (wr_ctl) begin
                slow_nxt = pwdata[CTL_SLOW];
                dual_nxt = pwdata[CTL_DUAL];
                hf_ext_nxt = pwdata[CTL_HF_EXT];
                vd_en_nxt = pwdata[CTL_VD_RESET_EN];
            end
            if (wr_wu) begin
                warmup_nxt = pwdata[7:0]; // [R05]
            end
            if (wr_tb) begin
                tb_en_nxt = pwdata[TB_ENABLE];
                tb_sel_nxt = pwdata[TB_SEL_LSB +: 3];
            end
        end
        if (acc_rd_setup) begin
            prdata_nxt = 32'h0000_0000;
            if (paddr == OFF_CONTROL) begin
                prdata_nxt[CTL_FULL_HALT] = in_stop_seq;
                prdata_nxt[CTL_LIGHT_HALT] = in_cpu_halt;
                prdata_nxt[CTL_TIMING_HALT] = in_tb_only;
                prdata_nxt[CTL_SLOW] = slow_r;
                prdata_nxt[CTL_DUAL] = dual_r;
                prdata_nxt[CTL_HF_EXT] = hf_ext_r;
                prdata_nxt[CTL_VD_RESET_EN] = vd_en_r;
            end else if (paddr == OFF_WARMUP) begin
                prdata_nxt[7:0] = warmup_r;
            end else if (paddr == OFF_TIMEBASE) begin
                prdata_nxt[TB_ENABLE] = tb_en_r;
                prdata_nxt[TB_SEL_LSB +: 3] = tb_sel_r;
            end else if (paddr == OFF_STATUS) begin
                prdata_nxt[3:0] = state_r;
                prdata_nxt[4] = sup_f_r;
                prdata_nxt[5] = from_reset_r;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            slow_r <= 1'b0;
            dual_r <= 1'b0;
            hf_ext_r <= 1'b0;
            vd_en_r <= 1'b0;
            warmup_r <= WARMUP_RST;
            tb_en_r <= TB_ENABLE_RST;
            tb_sel_r <= TB_SEL_RST;
            prdata_r <= PRDATA_RST;
        end else begin
            slow_r <= slow_nxt;
            dual_r <= dual_nxt;
            hf_ext_r <= hf_ext_nxt;
            vd_en_r <= vd_en_nxt;
            warmup_r <= warmup_nxt;
            tb_en_r <= tb_en_nxt;
            tb_sel_r <= tb_sel_nxt;
            prdata_r <= prdata_nxt;
        end
    end

    // mode sequencer
    always_comb begin
        state_nxt = state_r;
        cnt_nxt = cnt_r;
        saved_osc_nxt = saved_osc_r;
        ret_slow_nxt = ret_slow_r;
        from_reset_nxt = from_reset_r;
        tg_clear_nxt = 1'b0;
        resume_nxt = 1'b0;
        svc_nxt = 1'b0;
        tbl_nxt = 1'b0;
        case (state_r)
            ST_RUN_FAST, ST_RUN_SLOW: begin
                state_nxt = slow_r ? ST_RUN_SLOW : ST_RUN_FAST;
                if (wr_ctl && pwdata[CTL_FULL_HALT]) begin
                    state_nxt = ST_STOP;
                    saved_osc_nxt = osc_select(slow_r, dual_r, hf_ext_r); // [R07] [R08]
                    ret_slow_nxt = slow_r;
                    cnt_nxt = 12'h000;
                end else if (wr_ctl && pwdata[CTL_LIGHT_HALT]) begin
                    // a pending wake source or watchdog request cancels entry
                    if (!wake_irq && !watchdog_irq) begin // [R13] [R14]
                        state_nxt = slow_r ? ST_CPU_HALT_SLOW : ST_CPU_HALT_FAST; // [R24]
                        ret_slow_nxt = slow_r;
                    end
                end else if (wr_ctl && pwdata[CTL_TIMING_HALT]) begin
                    if (!watchdog_irq) begin // [R14]
                        state_nxt = slow_r ? ST_TB_ONLY_SLOW : ST_TB_ONLY_FAST; // [R24]
                        ret_slow_nxt = slow_r;
                    end
                end
            end
            ST_STOP: begin
                if (cnt_r < 12'(MACHINE_CYCLE_CLKS)) begin
                    cnt_nxt = cnt_r + 12'h001;
                end
                // a supply return in the first machine cycle is not a release
                if (supply_rise && (cnt_r >= 12'(MACHINE_CYCLE_CLKS))) begin // [R03]
                    state_nxt = ST_OSC_START; // [R04]
                end
            end
            ST_VD_RESET: begin
                if (sup_f_r) begin
                    state_nxt = ST_WARMUP; // [R02]
                    from_reset_nxt = 1'b1;
                    saved_osc_nxt = OSC_RESET;
                    cnt_nxt = WARMUP_RST_CLKS;
                end
            end
            ST_OSC_START: begin
                state_nxt = ST_WARMUP;
                from_reset_nxt = 1'b0;
                cnt_nxt = warmup_clks(warmup_r); // [R05]
            end
            ST_WARMUP: begin
                if (cnt_r == 12'h000) begin
                    if (from_reset_r) begin
                        state_nxt = ST_RUN_FAST; // [R02] [R16]
                    end else begin
                        state_nxt = ret_slow_r ? ST_RUN_SLOW : ST_RUN_FAST;
                        resume_nxt = 1'b1; // [R06]
                    end
                    tg_clear_nxt = 1'b1; // [R06]
                    from_reset_nxt = 1'b0;
                end else begin
                    cnt_nxt = cnt_r - 12'h001; // [R04]
                end
            end
            ST_CPU_HALT_FAST, ST_CPU_HALT_SLOW: begin
                if (wake_irq) begin
                    state_nxt = ret_slow_r ? ST_RUN_SLOW : ST_RUN_FAST; // [R15]
                    svc_nxt = master_irq_enable; // [R18]
                    resume_nxt = !master_irq_enable; // [R17]
                end
            end
            ST_TB_ONLY_FAST, ST_TB_ONLY_SLOW: begin
                if (tb_fall) begin
                    state_nxt = ret_slow_r ? ST_RUN_SLOW : ST_RUN_FAST; // [R21]
                    tbl_nxt = tb_en_r; // [R21]
                    svc_nxt = master_irq_enable && source_irq_enable[TB_IRQ_BIT] &&
                              tb_en_r; // [R23]
                    resume_nxt = !(master_irq_enable && source_irq_enable[TB_IRQ_BIT] &&
                                   tb_en_r); // [R22]
                end
            end
            default: begin
                state_nxt = ST_VD_RESET;
            end
        endcase
        // a detector reset ends stop, any halt and run alike
        if (vd_en_r && !sup_f_r && (state_r != ST_VD_RESET)) begin // [R01] [R16]
            state_nxt = ST_VD_RESET;
            tg_clear_nxt = 1'b0;
            resume_nxt = 1'b0;
            svc_nxt = 1'b0;
            tbl_nxt = 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_r <= ST_WARMUP;
            cnt_r <= WARMUP_RST_CLKS;
            saved_osc_r <= OSC_RESET;
            ret_slow_r <= 1'b0;
            from_reset_r <= 1'b1;
            tg_clear_r <= 1'b0;
            resume_r <= 1'b0;
            svc_r <= 1'b0;
            tbl_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            cnt_r <= cnt_nxt;
            saved_osc_r <= saved_osc_nxt;
            ret_slow_r <= ret_slow_nxt;
            from_reset_r <= from_reset_nxt;
            tg_clear_r <= tg_clear_nxt;
            resume_r <= resume_nxt;
            svc_r <= svc_nxt;
            tbl_r <= tbl_nxt;
        end
    end

    logic [2:0] osc_now;
    always_comb begin
        osc_now = 3'h0;
        if (in_run || in_cpu_halt || in_tb_only) begin
            osc_now = osc_select(slow_r, dual_r, hf_ext_r);
        end else if ((state_r == ST_OSC_START) || (state_r == ST_WARMUP)) begin
            osc_now = saved_osc_r; // [R07] [R08]
        end
    end

    assign prdata = prdata_r;
    assign vd_reset_out = (state_r == ST_VD_RESET); // [R01]
    assign cpu_stop = !in_run; // [R09] [R11]
    assign watchdog_stop = in_cpu_halt || in_stop_seq || (state_r == ST_VD_RESET); // [R09]
    // the cpu holds its pc, psw, registers and port latches while this is high
    assign state_freeze = in_cpu_halt || in_tb_only || in_stop_seq; // [R10] [R11]
    assign periph_clk_enable = in_run || in_cpu_halt; // [R09] [R19]
    assign timebase_clk_enable = in_run || in_cpu_halt || in_tb_only; // [R19]
    assign int_hf_osc_enable = osc_now[2];
    assign ext_hf_osc_enable = osc_now[1];
    assign ext_lf_osc_enable = osc_now[0];
    assign run_slow = (state_r == ST_RUN_SLOW);
    assign tg_clear = tg_clear_r;
    assign resume_next = resume_r;
    assign irq_service_request = svc_r;
    assign timebase_latch_set = tbl_r;
endmodule
`default_nettype wire

// ---- low_power_mode_sequencer_checker.sv ----
`default_nettype none
module low_power_mode_sequencer_checker (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic [7:0] paddr,
    input wire logic pslverr,
    input wire logic master_irq_enable,
    input wire logic [7:0] irq_latch,
    input wire logic [7:0] source_irq_enable,
    input wire logic vd_reset_out,
    input wire logic cpu_stop,
    input wire logic watchdog_stop,
    input wire logic state_freeze,
    input wire logic periph_clk_enable,
    input wire logic timebase_clk_enable,
    input wire logic tg_clear,
    input wire logic resume_next,
    input wire logic irq_service_request
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    sequence s_cpu_halt;
        cpu_stop && periph_clk_enable;
    endsequence
    sequence s_wake(m);
        s_cpu_halt ##0 (master_irq_enable == m) && (|(irq_latch & source_irq_enable));
    endsequence

    chk_vd_freeze: assert property (vd_reset_out |-> cpu_stop && !periph_clk_enable && !timebase_clk_enable)
        else $error("core not held while voltage reset is active");
    chk_vd_release: assert property ($fell(vd_reset_out) |-> cpu_stop && !watchdog_stop && !state_freeze)
        else $error("voltage reset release did not go to warm-up");
    chk_stop_freeze: assert property (watchdog_stop && state_freeze && !periph_clk_enable
        |-> cpu_stop && !timebase_clk_enable)
        else $error("clocks running during stop sequence");
    chk_halt_gate: assert property (s_cpu_halt |-> watchdog_stop && timebase_clk_enable && state_freeze)
        else $error("cpu halt gating wrong");
    chk_tb_only: assert property (cpu_stop && timebase_clk_enable && !periph_clk_enable
        |-> !watchdog_stop && state_freeze)
        else $error("timebase-only gating wrong");
    chk_halt_hold: assert property (s_cpu_halt ##0 !(|(irq_latch & source_irq_enable)) |=> cpu_stop)
        else $error("halt left without wake source");
    chk_halt_wake: assert property (s_wake(1'b0) or s_wake(1'b1) |=> !cpu_stop)
        else $error("halt not left on enabled latch");
    chk_wake_plain: assert property (s_wake(1'b0) |-> ##[1:2] resume_next)
        else $error("no resume pulse after plain wake");
    chk_wake_service: assert property (s_wake(1'b1) |-> ##[1:2] irq_service_request)
        else $error("no service request after wake");
    chk_tgc_run: assert property (tg_clear |-> !cpu_stop)
        else $error("timing clear outside run state");
    chk_apb_err: assert property (psel && penable
        |-> pslverr == !(paddr inside {8'h00, 8'h04, 8'h08, 8'h0C}))
        else $error("slave error does not follow address map");
endmodule

bind low_power_mode_sequencer low_power_mode_sequencer_checker i_chk (
    .pclk, .presetn, .psel, .penable, .paddr, .pslverr, .master_irq_enable, .irq_latch,
    .source_irq_enable, .vd_reset_out, .cpu_stop, .watchdog_stop, .state_freeze,
    .periph_clk_enable, .timebase_clk_enable, .tg_clear, .resume_next, .irq_service_request
);
`default_nettype wire

// ---- lpm_far_model.sv ----
`default_nettype none
module lpm_far_model (
    input wire logic pclk,
    input wire logic resume_next,
    input wire logic irq_service_request,
    input wire logic timebase_latch_set,
    output logic supply_ok,
    output logic master_irq_enable,
    output logic [7:0] irq_latch,
    output logic [7:0] source_irq_enable,
    output logic watchdog_irq,
    output logic [7:0] timebase_src_clk
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        supply_ok = 1'b1;
        master_irq_enable = 1'b0;
        irq_latch = 8'h00;
        source_irq_enable = 8'h00;
        watchdog_irq = 1'b0;
        timebase_src_clk = 8'h00;
    end
    // acceptance drops the master enable; any wake clears enabled latches
    always @(posedge pclk) begin
        if (irq_service_request || resume_next || timebase_latch_set) begin
            irq_latch <= (irq_latch | {2'b00, timebase_latch_set, 5'b00000}) &
                         ~((irq_service_request || resume_next) ? source_irq_enable : 8'h00);
        end
        if (irq_service_request) begin
            master_irq_enable <= 1'b0;
        end
    end
    // software sets enables before halting and clears the latch after a plain wake
    task automatic cpu(input logic m, input logic [7:0] en, input logic [7:0] lat, input logic wd);
        @(posedge pclk);
        master_irq_enable <= m;
        source_irq_enable <= en;
        irq_latch <= lat;
        watchdog_irq <= wd;
    endtask
    task automatic supply(input logic v);
        @(posedge pclk);
        supply_ok <= v;
    endtask
    // one source period; sources idle low so only this falling edge can wake
    task automatic tick(input int n);
        @(posedge pclk);
        timebase_src_clk[n] <= 1'b1;
        repeat (4) @(posedge pclk);
        timebase_src_clk[n] <= 1'b0;
        repeat (8) @(posedge pclk);
    endtask
endmodule
`default_nettype wire

// ---- lpm_seq_pkg.sv ----
`default_nettype none
package lpm_seq_pkg;
    localparam logic [7:0] OFF_CONTROL = 8'h00;
    localparam logic [7:0] OFF_WARMUP = 8'h04;
    localparam logic [7:0] OFF_TIMEBASE = 8'h08;
    localparam logic [7:0] OFF_STATUS = 8'h0C;

    localparam int CTL_FULL_HALT = 0;
    localparam int CTL_LIGHT_HALT = 1;
    localparam int CTL_TIMING_HALT = 2;
    localparam int CTL_SLOW = 3;
    localparam int CTL_DUAL = 4;
    localparam int CTL_HF_EXT = 5;
    localparam int CTL_VD_RESET_EN = 6;

    localparam int TB_ENABLE = 0;
    localparam int TB_SEL_LSB = 1;
    localparam int TB_IRQ_BIT = 5;

    localparam logic [7:0] WARMUP_RST = 8'h10;
    localparam logic TB_ENABLE_RST = 1'b0;
    localparam logic [2:0] TB_SEL_RST = 3'h0;
    localparam logic [31:0] PRDATA_RST = 32'h0000_0000;

    localparam logic [3:0] MACHINE_CYCLE_CLKS = 4'h4;
    localparam logic [11:0] WARMUP_UNIT_CLKS = 12'h010;
    localparam logic [11:0] WARMUP_RST_CLKS = 12'h100;

    // oscillator enable vector: {internal hf, external hf, external lf}
    localparam logic [2:0] OSC_RESET = 3'h4;

    typedef enum logic [3:0] {
        ST_RUN_FAST,
        ST_RUN_SLOW,
        ST_STOP,
        ST_VD_RESET,
        ST_OSC_START,
        ST_WARMUP,
        ST_CPU_HALT_FAST,
        ST_CPU_HALT_SLOW,
        ST_TB_ONLY_FAST,
        ST_TB_ONLY_SLOW
    } lpm_state_t;

    function automatic logic [2:0] osc_select(input logic slow, input logic dual,
                                               input logic hf_ext);
        logic [2:0] r;
        r = 3'h0;
        if (slow) begin
            r = 3'h1;
        end else begin
            r = hf_ext ? 3'h2 : 3'h4;
            r[0] = dual;
        end
        return r;
    endfunction

    function automatic logic [11:0] warmup_clks(input logic [7:0] w);
        return 12'(w) * WARMUP_UNIT_CLKS;
    endfunction
endpackage
`default_nettype wire

// ---- test_low_power_mode_sequencer.sv ----
`default_nettype none
module test_low_power_mode_sequencer
    import lpm_seq_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, supply_ok, master_irq_enable;
    logic watchdog_irq, vd_reset_out, cpu_stop, watchdog_stop, state_freeze, periph_clk_enable;
    logic timebase_clk_enable, int_hf_osc_enable, ext_hf_osc_enable, ext_lf_osc_enable, run_slow;
    logic tg_clear, resume_next, irq_service_request, timebase_latch_set, err;
    logic [7:0] paddr, irq_latch, source_irq_enable, timebase_src_clk;
    logic [31:0] pwdata, prdata, q;
    int mismatches, num_checks, cyc, k, n_res, n_tgc, n_svc, n_tbl;

    low_power_mode_sequencer i_dut (
        .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
        .pslverr, .supply_ok, .master_irq_enable, .irq_latch, .source_irq_enable,
        .watchdog_irq, .timebase_src_clk, .vd_reset_out, .cpu_stop, .watchdog_stop,
        .state_freeze, .periph_clk_enable, .timebase_clk_enable, .int_hf_osc_enable,
        .ext_hf_osc_enable, .ext_lf_osc_enable, .run_slow, .tg_clear, .resume_next,
        .irq_service_request, .timebase_latch_set
    );
    lpm_far_model i_far (
        .pclk, .resume_next, .irq_service_request, .timebase_latch_set, .supply_ok,
        .master_irq_enable, .irq_latch, .source_irq_enable, .watchdog_irq, .timebase_src_clk
    );

    initial begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end

    // pulses are one cycle wide, so count them rather than poll
    always @(posedge pclk) begin
        cyc++;
        if (resume_next === 1'b1) n_res++;
        if (tg_clear === 1'b1) n_tgc++;
        if (irq_service_request === 1'b1) n_svc++;
        if (timebase_latch_set === 1'b1) n_tbl++;
        if (cyc == 8000) begin
            mismatches++;
            summarize();
        end
    end

    task automatic summarize();
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("[ERR] %0t got %0h expected %0h", $time, got, exp);
        end
    endtask

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        q = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic st(input logic [3:0] e);
        apb(1'b0, OFF_STATUS, 32'h0);
        chk(32'(q[3:0]), 32'(e));
    endtask

    task automatic light(input logic m, input logic [31:0] ctl, input logic [3:0] hs,
                         input logic [3:0] rs);
        int a;
        int b;
        i_far.cpu(m, 8'h01, 8'h00, 1'b0);
        apb(1'b1, OFF_CONTROL, ctl);
        st(hs);
        chk(32'({cpu_stop, watchdog_stop, periph_clk_enable}), 32'h7);
        apb(1'b0, OFF_CONTROL, 32'h0);
        chk(32'(q[1]), 32'h1);
        a = n_res;
        b = n_svc;
        i_far.cpu(m, 8'h01, 8'h01, 1'b0);
        repeat (3) @(posedge pclk);
        st(rs);
        chk(n_res - a + 2 * (n_svc - b), m ? 32'h2 : 32'h1);
        apb(1'b0, OFF_CONTROL, 32'h0);
        chk(32'(q[1]), 32'h0);
        i_far.cpu(m, 8'h01, 8'h00, 1'b0);
    endtask

    task automatic tbh(input logic m, input logic tbe, input logic [31:0] er,
                       input logic [31:0] es, input logic [31:0] el);
        int a;
        int b;
        int c;
        apb(1'b1, OFF_TIMEBASE, {28'h0, 3'h3, tbe});
        i_far.cpu(m, {2'b00, m, 5'b00000}, 8'h00, 1'b0);
        apb(1'b1, OFF_CONTROL, 32'h4);
        st(4'h8);
        chk(32'({periph_clk_enable, timebase_clk_enable, watchdog_stop}), 32'h2);
        i_far.tick(2);
        st(4'h8);
        a = n_res;
        b = n_svc;
        c = n_tbl;
        i_far.tick(3);
        st(4'h0);
        chk(n_res - a, er);
        chk(n_svc - b, es);
        chk(n_tbl - c, el);
    endtask

    task automatic stp(input logic [31:0] ctl, input logic [31:0] osc, input logic [3:0] rs);
        int a;
        i_far.supply(1'b0);
        repeat (6) @(posedge pclk);
        i_far.supply(1'b1);
        apb(1'b1, OFF_CONTROL, ctl);
        repeat (20) @(posedge pclk);
        st(4'h2);
        chk(32'({int_hf_osc_enable, ext_hf_osc_enable, ext_lf_osc_enable}), 32'h0);
        i_far.supply(1'b0);
        repeat (8) @(posedge pclk);
        a = n_res;
        i_far.supply(1'b1);
        k = 0;
        while (cpu_stop !== 1'b0 && k < 300) begin
            @(posedge pclk);
            k++;
            if (k == 8) chk(32'({int_hf_osc_enable, ext_hf_osc_enable, ext_lf_osc_enable,
                state_freeze}), osc);
        end
        chk(32'(k >= 18 && k <= 27), 32'h1);
        st(rs);
        chk(n_res - a, 32'h1);
    endtask

    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        st(4'h5);
        chk(32'({cpu_stop, watchdog_stop, state_freeze}), 32'h4);
        repeat (270) @(posedge pclk);
        st(4'h0);
        chk(n_tgc, 32'h1);
        apb(1'b0, OFF_WARMUP, 32'h0);
        chk(q, 32'(WARMUP_RST));
        apb(1'b0, 8'h10, 32'h0);
        chk(32'(err), 32'h1);
        chk(q, 32'h0);
        i_far.cpu(1'b0, 8'h01, 8'h01, 1'b0);
        apb(1'b1, OFF_CONTROL, 32'h2);
        st(4'h0);
        i_far.cpu(1'b0, 8'h01, 8'h00, 1'b1);
        apb(1'b1, OFF_CONTROL, 32'h2);
        st(4'h0);
        light(1'b0, 32'h2, 4'h6, 4'h0);
        light(1'b1, 32'h2, 4'h6, 4'h0);
        apb(1'b1, OFF_CONTROL, 32'h8);
        repeat (2) @(posedge pclk);
        chk(32'(run_slow), 32'h1);
        light(1'b0, 32'hA, 4'h7, 4'h1);
        apb(1'b1, OFF_CONTROL, 32'h0);
        tbh(1'b0, 1'b1, 32'h1, 32'h0, 32'h1);
        tbh(1'b1, 1'b1, 32'h0, 32'h1, 32'h1);
        tbh(1'b0, 1'b0, 32'h1, 32'h0, 32'h0);
        apb(1'b1, OFF_WARMUP, 32'h1);
        // restart set follows the mode bits in force before the stop write
        stp(32'h31, 32'h9, 4'h0);
        stp(32'h01, 32'h7, 4'h0);
        apb(1'b1, OFF_CONTROL, 32'h8);
        stp(32'h09, 32'h3, 4'h1);
        apb(1'b1, OFF_CONTROL, 32'h40);
        i_far.supply(1'b0);
        repeat (8) @(posedge pclk);
        st(4'h3);
        i_far.supply(1'b1);
        repeat (8) @(posedge pclk);
        chk(32'({vd_reset_out, cpu_stop}), 32'h1);
        repeat (270) @(posedge pclk);
        st(4'h0);
        apb(1'b1, OFF_CONTROL, 32'h2);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        st(4'h5);
        repeat (270) @(posedge pclk);
        st(4'h0);
        summarize();
    end
endmodule
`default_nettype wire
